/* File: core/crp_pkg.sv */
// constants for the codec record and power register bank
package crp_pkg;
    // ***********************************************
    // register indices
    // ***********************************************
    localparam logic [6:0] IDX_RESET      = 7'h00;
    localparam logic [6:0] IDX_REC_SOURCE = 7'h1A;
    localparam logic [6:0] IDX_REC_GAIN   = 7'h1C;
    localparam logic [6:0] IDX_GP_LOOP    = 7'h20;
    localparam logic [6:0] IDX_POWER      = 7'h26;
    localparam logic [6:0] IDX_EXT_ID     = 7'h28;
    // ***********************************************
    // reset values and writable masks
    // ***********************************************
    localparam logic [15:0] RST_REC_SOURCE  = 16'h0000;
    localparam logic [15:0] RST_REC_GAIN    = 16'h8000;
    localparam logic [15:0] RST_GP_LOOP     = 16'h0000;
    localparam logic [15:0] RST_POWER       = 16'h0000;
    localparam logic [15:0] EXT_ID_VALUE    = 16'h0001;
    localparam logic [15:0] MASK_REC_SOURCE = 16'h0707;
    localparam logic [15:0] MASK_REC_GAIN   = 16'h8F0F;
    localparam logic [15:0] MASK_GP_LOOP    = 16'h0080;
    localparam logic [15:0] MASK_POWER_CTRL = 16'h3B00;
    // ***********************************************
    // field positions
    // ***********************************************
    localparam int LSRC_LSB   = 8;
    localparam int RSRC_LSB   = 0;
    localparam int SRC_W      = 3;
    localparam int LGAIN_LSB  = 8;
    localparam int RGAIN_LSB  = 0;
    localparam int GAIN_W     = 4;
    localparam int MUTE_BIT   = 15;
    localparam int LOOP_BIT   = 7;
    localparam int CLKOFF_BIT = 13;
    localparam int LINKPD_BIT = 12;
    localparam int REFPD_BIT  = 11;
    localparam int DACPD_BIT  = 9;
    localparam int ADCPD_BIT  = 8;
    localparam int REFRDY_BIT = 3;
    localparam int DACRDY_BIT = 1;
    localparam int ADCRDY_BIT = 0;
    // ***********************************************
    // source codes and mux selections
    // ***********************************************
    localparam logic [2:0] SRC_MIC_OR_COPY = 3'h0;
    localparam logic [2:0] SRC_LINE        = 3'h4;
    localparam logic [1:0] SEL_MIC         = 2'h0;
    localparam logic [1:0] SEL_LINE_L      = 2'h1;
    localparam logic [1:0] SEL_LINE_R      = 2'h2;
    localparam logic [1:0] SEL_COPY_LEFT   = 2'h3;
    localparam logic [1:0] SEL_NONE        = 2'h3;
    // the right channel never selects the microphone, so that code marks a reserved source
    localparam logic [1:0] SEL_RIGHT_NONE  = 2'h0;
    // gain step in tenths of a decibel
    localparam int GAIN_STEP_DB_X10 = 15;
endpackage : crp_pkg

/* File: core/crp_regs.sv */
// record source, record gain, loopback and power-down register bank
// Clocking
// registers, read path and audio muxes all run on the link bit clock
// the master clock is only watched: a sticky flag set in its own domain
// crosses on two flip-flops and holds codec ready low until it is seen
// the analog ready levels cross the same way and are shown live, not stored
// codec ready follows the master clock flag alone and does not wait for the status synchronisers
//
// Limitations
// power-down bits are plain outputs; this bank keeps running while they
// are set, so the analog side has to do the actual gating
// reserved source codes give a silent channel rather than a guess
// a reserved right source shows select code 0, never used by the right
// channel otherwise, so it cannot be mistaken for copy mode
// a register reset through index 0x00 beats any write in the same slot
// a read in the slot of a write to the same index returns the old value
// record and loopback data lag the configuration by one link clock
// mute zeroes record data and therefore the looped-back data as well
// reads of unlisted indices and of index 0x00 return zero
// link-side strobes come from the same clock and are not resynchronised
`timescale 1ns/10ps
module crp_regs #(
    parameter int DATA_W = 20
) (
    input  wire logic              mclk_in,
    input  wire logic              resetn_in,
    input  wire logic              bit_clk_in,
    input  wire logic              wr_strobe_in,
    input  wire logic              rd_strobe_in,
    input  wire logic [6:0]        reg_index_in,
    input  wire logic [15:0]       wr_data_in,
    output logic      [15:0]       rd_data_out,
    output logic                   rd_valid_out,
    output logic                   codec_ready_out,
    input  wire logic              ref_ok_in,
    input  wire logic              dac_ok_in,
    input  wire logic              adc_ok_in,
    input  wire logic [DATA_W-1:0] mic_data_in,
    input  wire logic [DATA_W-1:0] line_l_data_in,
    input  wire logic [DATA_W-1:0] line_r_data_in,
    input  wire logic [DATA_W-1:0] link_dac_l_in,
    input  wire logic [DATA_W-1:0] link_dac_r_in,
    output logic      [DATA_W-1:0] rec_l_data_out,
    output logic      [DATA_W-1:0] rec_r_data_out,
    output logic      [DATA_W-1:0] dac_l_data_out,
    output logic      [DATA_W-1:0] dac_r_data_out,
    output logic      [1:0]        left_rec_source_sel_out,
    output logic      [1:0]        right_rec_source_sel_out,
    output logic      [3:0]        left_rec_gain_out,
    output logic      [3:0]        right_rec_gain_out,
    output logic                   record_mute_out,
    output logic                   adc_to_dac_loop_out,
    output logic                   internal_clock_off_out,
    output logic                   link_powerdown_out,
    output logic                   reference_powerdown_out,
    output logic                   dac_path_powerdown_out,
    output logic                   adc_path_powerdown_out,
    output logic      [7:0]        gain_db_x10_l_out,
    output logic      [7:0]        gain_db_x10_r_out
);
    // ***********************************************
    // helpers
    // ***********************************************
    // gain code to tenths of a decibel, shared by both channels
    function automatic logic [7:0] gain_db_x10(input logic [3:0] code);
        gain_db_x10 = 8'(code * crp_pkg::GAIN_STEP_DB_X10);
    endfunction : gain_db_x10

    // merge a write into a register keeping only its writable bits
    function automatic logic [15:0] masked_write(input logic [15:0] data, input logic [15:0] mask);
        masked_write = data & mask;
    endfunction : masked_write

    // only two source codes select anything; the rest are reserved
    function automatic logic source_known(input logic [2:0] code);
        source_known = (code == crp_pkg::SRC_MIC_OR_COPY) || (code == crp_pkg::SRC_LINE);
    endfunction : source_known

    // ***********************************************
    // status synchronisers
    // ***********************************************
    logic [2:0] ready_sync;

    // analog ready flags arrive asynchronously to the link clock
    crp_sync2 #(
        .W (3)
    ) u_ready_sync (
        .clk_in    (bit_clk_in),
        .resetn_in (resetn_in),
        .d_in      ({ref_ok_in, dac_ok_in, adc_ok_in}),
        .q_out     (ready_sync)
    );

    // ***********************************************
    // master clock presence
    // ***********************************************
    logic mclk_seen;
    logic mclk_seen_sync;

    // sticky level in the master domain, so a plain two-flop crossing is safe
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mclk_seen <= 1'b0;
        end else begin
            mclk_seen <= 1'b1;
        end
    end

    // nothing in the link domain reads the flag before it has crossed
    crp_sync2 #(
        .W (1)
    ) u_mclk_sync (
        .clk_in    (bit_clk_in),
        .resetn_in (resetn_in),
        .d_in      (mclk_seen),
        .q_out     (mclk_seen_sync)
    );

    // ***********************************************
    // register file on the link clock
    // ***********************************************
    logic [15:0] record_source_select;
    logic [15:0] record_gain_mute;
    logic [15:0] general_purpose_loopback;
    logic [15:0] power_down_ctrl;
    logic        regs_up;

    wire write_reset  = wr_strobe_in && (reg_index_in == crp_pkg::IDX_RESET);
    wire write_source = wr_strobe_in && (reg_index_in == crp_pkg::IDX_REC_SOURCE);
    wire write_gain   = wr_strobe_in && (reg_index_in == crp_pkg::IDX_REC_GAIN);
    wire write_gp     = wr_strobe_in && (reg_index_in == crp_pkg::IDX_GP_LOOP);
    wire write_power  = wr_strobe_in && (reg_index_in == crp_pkg::IDX_POWER);

    // record source select; a register reset wins over a same-slot write
    always_ff @(posedge bit_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            record_source_select <= crp_pkg::RST_REC_SOURCE;
        end else if (write_reset) begin
            record_source_select <= crp_pkg::RST_REC_SOURCE;
        end else if (write_source) begin
            record_source_select <= masked_write(wr_data_in, crp_pkg::MASK_REC_SOURCE);
        end
    end

    // record gain and mute
    always_ff @(posedge bit_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            record_gain_mute <= crp_pkg::RST_REC_GAIN;
        end else if (write_reset) begin
            record_gain_mute <= crp_pkg::RST_REC_GAIN;
        end else if (write_gain) begin
            record_gain_mute <= masked_write(wr_data_in, crp_pkg::MASK_REC_GAIN);
        end
    end

    // loopback control
    always_ff @(posedge bit_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            general_purpose_loopback <= crp_pkg::RST_GP_LOOP;
        end else if (write_reset) begin
            general_purpose_loopback <= crp_pkg::RST_GP_LOOP;
        end else if (write_gp) begin
            general_purpose_loopback <= masked_write(wr_data_in, crp_pkg::MASK_GP_LOOP);
        end
    end

    // power-down controls; the status half is never stored, only muxed on read
    always_ff @(posedge bit_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            power_down_ctrl <= crp_pkg::RST_POWER;
        end else if (write_reset) begin
            power_down_ctrl <= crp_pkg::RST_POWER;
        end else if (write_power) begin
            power_down_ctrl <= masked_write(wr_data_in, crp_pkg::MASK_POWER_CTRL);
        end
    end

    // codec ready waits for the master clock flag to cross into this domain
    always_ff @(posedge bit_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            regs_up <= 1'b0;
        end else begin
            regs_up <= mclk_seen_sync;
        end
    end

    // codec ready only after the register file has left reset
    assign codec_ready_out = regs_up;

    // ***********************************************
    // read path
    // ***********************************************
    logic [15:0] live_status;

    // ready flags placed by position; every other status bit reads zero
    always_comb begin
        live_status = 16'h0000;
        live_status[crp_pkg::REFRDY_BIT] = ready_sync[2];
        live_status[crp_pkg::DACRDY_BIT] = ready_sync[1];
        live_status[crp_pkg::ADCRDY_BIT] = ready_sync[0];
    end

    logic [15:0] next_rd_data;

    // unlisted indices read zero; reads also go through the reset index as zero
    always_comb begin
        next_rd_data = 16'h0000;
        unique case (reg_index_in)
            crp_pkg::IDX_REC_SOURCE: next_rd_data = record_source_select;
            crp_pkg::IDX_REC_GAIN:   next_rd_data = record_gain_mute;
            crp_pkg::IDX_GP_LOOP:    next_rd_data = general_purpose_loopback;
            crp_pkg::IDX_POWER:      next_rd_data = power_down_ctrl | live_status;
            crp_pkg::IDX_EXT_ID:     next_rd_data = crp_pkg::EXT_ID_VALUE;
            default:                 next_rd_data = 16'h0000;
        endcase
    end

    // read data held in a flop so the slot builder sees a stable word
    always_ff @(posedge bit_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_data_out  <= 16'h0000;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_strobe_in;
            if (rd_strobe_in) begin
                rd_data_out <= next_rd_data;
            end
        end
    end

    // ***********************************************
    // field decode
    // ***********************************************
    wire [2:0] left_rec_source  = record_source_select[crp_pkg::LSRC_LSB +: crp_pkg::SRC_W];
    wire [2:0] right_rec_source = record_source_select[crp_pkg::RSRC_LSB +: crp_pkg::SRC_W];
    wire [3:0] left_rec_gain    = record_gain_mute[crp_pkg::LGAIN_LSB +: crp_pkg::GAIN_W];
    wire [3:0] right_rec_gain   = record_gain_mute[crp_pkg::RGAIN_LSB +: crp_pkg::GAIN_W];
    wire       copy_left        = (right_rec_source == crp_pkg::SRC_MIC_OR_COPY);

    // reserved source codes select nothing and give silence
    wire [1:0] left_sel  = (left_rec_source == crp_pkg::SRC_MIC_OR_COPY) ? crp_pkg::SEL_MIC :
                           (left_rec_source == crp_pkg::SRC_LINE) ? crp_pkg::SEL_LINE_L :
                           crp_pkg::SEL_NONE;
    wire       left_live = source_known(left_rec_source);
    wire [1:0] right_sel = copy_left ? crp_pkg::SEL_COPY_LEFT :
                           (right_rec_source == crp_pkg::SRC_LINE) ? crp_pkg::SEL_LINE_R :
                           crp_pkg::SEL_RIGHT_NONE;
    wire       right_live = source_known(right_rec_source);

    // in copy mode the right gain field is ignored
    wire [3:0] eff_right_gain = copy_left ? left_rec_gain : right_rec_gain;

    wire loop_on = general_purpose_loopback[crp_pkg::LOOP_BIT];

    // ***********************************************
    // control outputs
    // ***********************************************
    logic [DATA_W-1:0] next_rec_l;
    logic [DATA_W-1:0] next_rec_r;

    // source muxing; mute forces zero without losing the selection
    always_comb begin
        next_rec_l = '0;
        next_rec_r = '0;
        if (left_live && !record_mute_out) begin
            next_rec_l = (left_sel == crp_pkg::SEL_MIC) ? mic_data_in : line_l_data_in;
        end
        if (right_live && !record_mute_out) begin
            next_rec_r = copy_left ? next_rec_l : line_r_data_in;
        end
    end

    // record data flops
    always_ff @(posedge bit_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rec_l_data_out <= '0;
            rec_r_data_out <= '0;
        end else begin
            rec_l_data_out <= next_rec_l;
            rec_r_data_out <= next_rec_r;
        end
    end

    // loopback takes the muxed record word, so it never touches the link
    always_ff @(posedge bit_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dac_l_data_out <= '0;
            dac_r_data_out <= '0;
        end else begin
            dac_l_data_out <= loop_on ? next_rec_l : link_dac_l_in;
            dac_r_data_out <= loop_on ? next_rec_r : link_dac_r_in;
        end
    end

    assign left_rec_source_sel_out  = left_sel;
    assign right_rec_source_sel_out = right_sel;
    assign left_rec_gain_out        = left_rec_gain;
    assign right_rec_gain_out       = eff_right_gain;
    assign gain_db_x10_l_out        = gain_db_x10(left_rec_gain);
    assign gain_db_x10_r_out        = gain_db_x10(eff_right_gain);
    assign record_mute_out          = record_gain_mute[crp_pkg::MUTE_BIT];
    assign adc_to_dac_loop_out      = loop_on;

    // ***********************************************
    // power-down outputs
    // ***********************************************
    // straight from the register; gating belongs to the analog side
    assign internal_clock_off_out   = power_down_ctrl[crp_pkg::CLKOFF_BIT];
    assign link_powerdown_out       = power_down_ctrl[crp_pkg::LINKPD_BIT];
    assign reference_powerdown_out  = power_down_ctrl[crp_pkg::REFPD_BIT];
    assign dac_path_powerdown_out   = power_down_ctrl[crp_pkg::DACPD_BIT];
    assign adc_path_powerdown_out   = power_down_ctrl[crp_pkg::ADCPD_BIT];
endmodule : crp_regs

/* File: core/crp_sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/10ps
module crp_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta;

    // meta is read only by the second stage
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta  <= '0;
            q_out <= '0;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule : crp_sync2

/* File: tb/crp_host_model.sv */
// behavioural link host controller issuing register accesses
`timescale 1ns/10ps
module crp_host_model (
    input  wire logic        bit_clk_in,
    output logic             wr_strobe_out,
    output logic             rd_strobe_out,
    output logic      [6:0]  reg_index_out,
    output logic      [15:0] wr_data_out
);
    initial begin
        {wr_strobe_out, rd_strobe_out, reg_index_out, wr_data_out} = '0;
    end
    // one access per call, held over one edge; on release the strobes drop and index and data show inverted values
    task automatic access(input logic wr, input logic [6:0] i, input logic [15:0] d);
        @(posedge bit_clk_in);
        {wr_strobe_out, rd_strobe_out, reg_index_out, wr_data_out} <= {wr, ~wr, i, d};
        @(posedge bit_clk_in);
        {wr_strobe_out, rd_strobe_out, reg_index_out, wr_data_out} <= {2'b00, ~i, ~d};
    endtask : access
endmodule : crp_host_model

/* File: tb/crp_regs_props.sv */
// assertions on the ports of the record and power register bank
`timescale 1ns/10ps
module crp_regs_props #(
    parameter int DATA_W = 20
) (
    input  wire logic              bit_clk_in,
    input  wire logic              resetn_in,
    input  wire logic              wr_strobe_in,
    input  wire logic              rd_strobe_in,
    input  wire logic [6:0]        reg_index_in,
    input  wire logic [15:0]       rd_data_out,
    input  wire logic              codec_ready_out,
    input  wire logic [DATA_W-1:0] rec_l_data_out,
    input  wire logic [DATA_W-1:0] rec_r_data_out,
    input  wire logic [DATA_W-1:0] dac_l_data_out,
    input  wire logic [1:0]        right_rec_source_sel_out,
    input  wire logic [3:0]        left_rec_gain_out,
    input  wire logic              record_mute_out,
    input  wire logic              adc_to_dac_loop_out,
    input  wire logic [7:0]        gain_db_x10_l_out
);
    default clocking cb @(posedge bit_clk_in); endclocking
    default disable iff (!resetn_in);
    // ***********************************************
    // register answers and audio routing
    // ***********************************************
    chk_ext_id_word: assert property (rd_strobe_in && reg_index_in == 7'h28 |=> rd_data_out == 16'h0001)
        else $error("identification word wrong");
    chk_power_reserved: assert property (rd_strobe_in && reg_index_in == 7'h26 |=> (rd_data_out & 16'hC4F4) == 0)
        else $error("reserved power bits not zero");
    chk_soft_reset: assert property (wr_strobe_in && reg_index_in == 7'h00 |=> record_mute_out
        && left_rec_gain_out == 4'h0 && !adc_to_dac_loop_out && right_rec_source_sel_out == 2'h3)
        else $error("register reset left a value behind");
    chk_mute_silence: assert property (record_mute_out |=> rec_l_data_out == 0 && rec_r_data_out == 0)
        else $error("muted record data not silent");
    chk_copy_left: assert property (right_rec_source_sel_out == 2'h3 |=> rec_r_data_out == rec_l_data_out)
        else $error("right channel not a copy of left");
    chk_gain_steps: assert property (gain_db_x10_l_out == 8'(left_rec_gain_out * 15))
        else $error("left gain not in 1.5 dB steps");
    chk_loop_route: assert property (adc_to_dac_loop_out |=> dac_l_data_out == rec_l_data_out)
        else $error("loopback did not feed the dac");
    chk_ready_hold: assert property (codec_ready_out |=> codec_ready_out)
        else $error("codec ready dropped while running");
endmodule : crp_regs_props
bind crp_regs crp_regs_props #(.DATA_W(DATA_W)) u_props (.*);

/* File: tb/tb_top.sv */
// self-checking bench for the record and power register bank
`timescale 1ns/10ps
module tb_top;
    logic          mclk_in = 1'b0;
    logic          bit_clk = 1'b0;
    logic          resetn = 1'b0;
    logic          wr_s, rd_s, rd_valid, ready, ref_ok, dac_ok, adc_ok;
    logic [6:0]    idx;
    logic [15:0]   wdat, rd_data, status;
    logic [19:0]   mic, line_l, line_r, link_l, link_r, rec_l, rec_r, dac_l, dac_r, e_l, e_r;
    logic [3:0]    lgain, rgain, e_g;
    logic [1:0]    lsel, rsel;
    logic [7:0]    ldb, rdb;
    wire  [6:0]    pd;
    logic [31:0]   seed = 32'h66E7;
    logic [15:0]   exp_q[$];
    logic [6:0]    idx_tab[5] = '{7'h1A, 7'h1C, 7'h20, 7'h26, 7'h28};
    logic [15:0]   msk_tab[5] = '{16'h0707, 16'h8F0F, 16'h0080, 16'h3B02, 16'h0001};
    int            failures = 0;
    int            checks = 0;
    real           half_bit = 66.6;
    // odd first half period keeps the link clock off the master clock phase
    always #12.5 mclk_in = ~mclk_in;
    always begin
        #half_bit;
        half_bit = 62.5;
        bit_clk = ~bit_clk;
    end
    crp_host_model u_host (.bit_clk_in(bit_clk), .wr_strobe_out(wr_s), .rd_strobe_out(rd_s),
        .reg_index_out(idx), .wr_data_out(wdat));
    crp_regs #(.DATA_W(20)) u_dut (.mclk_in(mclk_in), .resetn_in(resetn), .bit_clk_in(bit_clk),
        .wr_strobe_in(wr_s), .rd_strobe_in(rd_s), .reg_index_in(idx), .wr_data_in(wdat), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid), .codec_ready_out(ready), .ref_ok_in(ref_ok), .dac_ok_in(dac_ok),
        .adc_ok_in(adc_ok), .mic_data_in(mic), .line_l_data_in(line_l), .line_r_data_in(line_r),
        .link_dac_l_in(link_l), .link_dac_r_in(link_r), .rec_l_data_out(rec_l), .rec_r_data_out(rec_r),
        .dac_l_data_out(dac_l), .dac_r_data_out(dac_r),
        .left_rec_source_sel_out(lsel), .right_rec_source_sel_out(rsel),
        .left_rec_gain_out(lgain), .right_rec_gain_out(rgain), .record_mute_out(pd[6]),
        .adc_to_dac_loop_out(pd[5]), .internal_clock_off_out(pd[4]), .link_powerdown_out(pd[3]),
        .reference_powerdown_out(pd[2]), .dac_path_powerdown_out(pd[1]), .adc_path_powerdown_out(pd[0]),
        .gain_db_x10_l_out(ldb), .gain_db_x10_r_out(rdb));
    // ***********************************************
    // helpers
    // ***********************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string name, input logic [19:0] exp, input logic [19:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic rd(input logic [6:0] i, input logic [15:0] e);
        exp_q.push_back(e);
        u_host.access(1'b0, i, 16'h0000);
    endtask : rd
    task automatic read_defaults;
        rd(7'h1A, 16'h0000);
        rd(7'h1C, 16'h8000);
        rd(7'h20, 16'h0000);
        rd(7'h26, status);
        rd(7'h28, 16'h0001);
        rd(7'h30, 16'h0000);
    endtask : read_defaults
    task automatic complete_run;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    // read answers are matched against the oldest note once settled
    always @(negedge bit_clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0)
                check("read_extra", 20'h0, 20'h1);
            else
                check("rd_data", 20'(exp_q.pop_front()), 20'(rd_data));
        end
    end
    // ***********************************************
    // main sequence
    // ***********************************************
    initial begin
        {ref_ok, dac_ok, adc_ok} = 3'b101;
        {mic, line_l, line_r, link_l, link_r} = '0;
        status = 16'h0009;
        repeat (16) @(posedge bit_clk);
        check("mute_in_reset", 20'h1, 20'(pd[6]));
        resetn <= 1'b1;
        for (int n = 0; n < 8 && ready !== 1'b1; n++) @(negedge bit_clk);
        check("codec_ready", 20'h1, 20'(ready));
        if (ready !== 1'b1)
            complete_run();
        read_defaults();
        // all ones everywhere: only documented bits stick, status stays live
        {ref_ok, dac_ok, adc_ok} <= 3'b010;
        status = 16'h0002;
        for (int k = 0; k < 5; k++) u_host.access(1'b1, idx_tab[k], 16'hFFFF);
        for (int k = 0; k < 5; k++) rd(idx_tab[k], msk_tab[k]);
        check("control_bits", 20'h7F, 20'(pd));
        u_host.access(1'b1, 7'h00, 16'h5A5A);
        read_defaults();
        check("control_reset", 20'h40, 20'(pd));
        // every source code on both channels, random gains, loop and audio
        for (int c = 0; c < 8; c++) begin
            seed = lfsr(lfsr(seed));
            u_host.access(1'b1, 7'h1A, {5'h00, 3'(c), 5'h00, 3'(c)});
            u_host.access(1'b1, 7'h1C, {4'h0, seed[11:8], 4'h0, seed[3:0]});
            u_host.access(1'b1, 7'h20, {8'h00, seed[16], 7'h00});
            {mic, line_l, line_r} <= {20'(seed), 20'(seed >> 5), 20'(~seed)};
            {link_l, link_r} <= {20'(seed >> 9), 20'(seed >> 12)};
            @(posedge bit_clk);
            @(negedge bit_clk);
            e_l = (c == 0) ? mic : (c == 4) ? line_l : 20'h0;
            e_r = (c == 0) ? e_l : (c == 4) ? line_r : 20'h0;
            e_g = (c == 0) ? seed[11:8] : seed[3:0];
            check("rec_l", e_l, rec_l);
            check("rec_r", e_r, rec_r);
            check("sel_l", (c == 0) ? 20'h0 : (c == 4) ? 20'h1 : 20'h3, 20'(lsel));
            check("sel_r", (c == 0) ? 20'h3 : (c == 4) ? 20'h2 : 20'h0, 20'(rsel));
            check("gain_l", 20'(seed[11:8]), 20'(lgain));
            check("gain_r", 20'(e_g), 20'(rgain));
            check("db_l", 20'(seed[11:8] * 15), 20'(ldb));
            check("db_r", 20'(e_g * 15), 20'(rdb));
            check("dac_l", seed[16] ? e_l : link_l, dac_l);
            check("dac_r", seed[16] ? e_r : link_r, dac_r);
        end
        u_host.access(1'b1, 7'h1A, 16'h0404);
        u_host.access(1'b1, 7'h1C, 16'h8000);
        @(posedge bit_clk);
        @(negedge bit_clk);
        check("muted_rec", 20'h0, rec_l | rec_r);
        repeat (2) @(negedge bit_clk);
        check("reads_left", 20'h0, 20'(exp_q.size()));
        complete_run();
    end
endmodule : tb_top
